// ---- shared/serial_pkg.sv ----
/*
 * Constants and types shared by the three-wire serial master channel:
 * register offsets, field positions, reset values and the shift states.
 * Assumes a 32-bit APB with byte addresses, one aligned word per register.
 */
package serial_pkg;

  // Register byte offsets.
  localparam logic [7:0] MODE_OFS   = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] BAUD_OFS   = 8'h08;
  localparam logic [7:0] DATA_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] CLEAR_OFS  = 8'h14;
  localparam logic [7:0] START_OFS  = 8'h18;
  localparam logic [7:0] OUTCTL_OFS = 8'h1C;

  // Field positions in the channel mode register.
  localparam int MODE_IRQ_SRC_BIT = 0;
  localparam int MODE_PRESC_LSB   = 4;

  // Field positions in the communication configuration register.
  localparam int CONFIG_DAP_BIT = 0;
  localparam int CONFIG_CKP_BIT = 1;
  localparam int CONFIG_LSB_BIT = 2;
  localparam int CONFIG_LEN_LSB = 4;

  // Field positions in the status, clear, start and output registers.
  localparam int STATUS_OVR_BIT   = 0;
  localparam int STATUS_FULL_BIT  = 1;
  localparam int STATUS_BUSY_BIT  = 2;
  localparam int CLEAR_OVR_BIT    = 0;
  localparam int START_RUN_BIT    = 0;
  localparam int START_STOP_BIT   = 1;
  localparam int OUTCTL_OE_BIT    = 0;
  localparam int OUTCTL_CKIDL_BIT = 1;
  localparam int OUTCTL_DTIDL_BIT = 2;

  // Values after reset.
  localparam logic [3:0] PRESC_RST  = 4'h0;
  localparam logic [3:0] LEN_M1_RST = 4'h7;
  localparam logic [6:0] BAUD_RST   = 7'h00;
  localparam logic [2:0] OUTCTL_RST = 3'h6;

  // Limits of the word length (less one) and of the prescaler exponent.
  localparam logic [3:0] LEN_M1_MIN = 4'h6;
  localparam logic [3:0] PRESC_MAX  = 4'hB;

  // Shift sequencer states.
  typedef enum logic [1:0] {
    idle_st,
    lead_st,
    low_st,
    high_st
  } state_type;

endpackage : serial_pkg

// ---- rtl/baud_tick_gen.sv ----
/*
 * Half-period tick generator for the serial clock.
 * Assumes the caller holds run low between transfers so each starts fresh.
 */
`timescale 1ns/100ps
module baud_tick_gen (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Rate selection and control.
  input  wire logic       run,
  input  wire logic [3:0] presc,
  input  wire logic [6:0] divider,
  // Tick once per half serial clock period.
  output logic            tick
);

  logic [17:0] cnt_reg;
  logic [17:0] cnt_next;
  logic [17:0] reload;

  // Half period is (divider + 1) times two to the prescaler exponent.
  always_comb begin
    reload   = ({11'h000, divider} + 18'h00001) << presc;
    reload   = reload - 18'h00001;
    tick     = run && (cnt_reg == reload);
    cnt_next = (!run || tick) ? 18'h00000 : cnt_reg + 18'h00001;
  end

  // Counter register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 18'h00000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : baud_tick_gen

// ---- rtl/serial_shifter.sv ----
/*
 * Transmit and receive shift register with selectable bit order and
 * word length. Assumes load and shift requests never coincide.
 */
`timescale 1ns/100ps
module serial_shifter #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Control.
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_word,
  input  wire logic             shift_out,
  input  wire logic             shift_in,
  input  wire logic             in_bit,
  input  wire logic             lsb_first,
  input  wire logic [3:0]       len_m1,
  // Results.
  output logic                  out_bit,
  output logic [WIDTH-1:0]      rx_word
);

  logic [WIDTH-1:0] tx_reg;
  logic [WIDTH-1:0] tx_next;
  logic [WIDTH-1:0] rx_reg;
  logic [WIDTH-1:0] rx_next;

  // Shift out from the chosen end, shift in toward the opposite end.
  always_comb begin
    tx_next = tx_reg;
    rx_next = rx_reg;
    if (load) begin
      tx_next = load_word;
      rx_next = '0;
    end
    if (shift_out) begin
      tx_next = lsb_first ? (tx_reg >> 1) : (tx_reg << 1);
    end
    if (shift_in) begin
      if (lsb_first) begin
        rx_next         = rx_reg >> 1;
        rx_next[len_m1] = in_bit;
      end else begin
        rx_next = {rx_reg[WIDTH-2:0], in_bit};
      end
    end
    out_bit = lsb_first ? tx_reg[0] : tx_reg[len_m1];
    rx_word = rx_reg;
  end

  // Shift registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_reg <= '0;
      rx_reg <= '0;
    end else begin
      tx_reg <= tx_next;
      rx_reg <= rx_next;
    end
  end

endmodule : serial_shifter

// ---- rtl/three_wire_channel.sv ----
/*
 * Master transmit and receive channel of a three-wire serial interface,
 * with its register file on APB. Assumes the serial input is synchronous
 * to clk and that the port logic outside honours serial_out_oe.
 */
`timescale 1ns/100ps

module three_wire_channel (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins.
  output logic             serial_clock_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  input  wire logic        serial_in_pin,
  // Transfer interrupt pulse.
  output logic             channel_transfer_irq
);

  // Software-visible state, with the internal unread flag.
  logic                    irq_src_reg, irq_src_next;
  logic [3:0]              presc_reg, presc_next;
  logic                    dap_reg, dap_next;
  logic                    ckp_reg, ckp_next;
  logic                    lsb_reg, lsb_next;
  logic [3:0]              len_m1_reg, len_m1_next;
  logic [6:0]              baud_reg, baud_next;
  logic [15:0]             tx_buf_reg, tx_buf_next;
  logic [15:0]             rx_data_reg, rx_data_next;
  logic                    full_reg, full_next;
  logic                    unread_reg, unread_next;
  logic                    overrun_flag, overrun_next;
  logic                    enable_reg, enable_next;
  logic                    oe_reg, oe_next;
  logic                    ck_idle_reg, ck_idle_next;
  logic                    dt_idle_reg, dt_idle_next;
  // Bus answer state.
  logic [31:0]             prdata_reg, prdata_next;
  logic                    pready_reg, pready_next;
  logic                    pslverr_reg, pslverr_next;
  // Shift sequencer state.
  serial_pkg::state_type   state_reg, state_next;
  logic [3:0]              cnt_reg, cnt_next;
  logic                    sclk_reg, sclk_next;
  logic                    sdo_reg, sdo_next;
  logic                    irq_reg, irq_next;
  // Internal strobes.
  logic                    wr_ok, rd_ok, hit;
  logic [31:0]             rd_word;
  logic                    tick, load, shift_out, shift_in, finish;
  logic                    last_bit, out_bit;
  logic [15:0]             rx_word;
  logic [3:0]              len_wr, presc_wr;

  // Half-period ticks only while a word is being shifted.
  baud_tick_gen u_tick (
    .clk     (clk),
    .rst     (rst),
    .run     (state_reg != serial_pkg::idle_st),
    .presc   (presc_reg),
    .divider (baud_reg),
    .tick    (tick)
  );

  // Transmit and receive share one shifter, so both words end together.
  serial_shifter #(.WIDTH(16)) u_shift (
    .clk       (clk),
    .rst       (rst),
    .load      (load),
    .load_word (tx_buf_reg),
    .shift_out (shift_out),
    .shift_in  (shift_in),
    .in_bit    (serial_in_pin),
    .lsb_first (lsb_reg),
    .len_m1    (len_m1_reg),
    .out_bit   (out_bit),
    .rx_word   (rx_word)
  );

  // Bus decode; a transfer completes at the edge where pready is high.
  always_comb begin
    wr_ok    = psel && penable && pready_reg && pwrite;
    rd_ok    = psel && penable && pready_reg && !pwrite;
    len_wr   = pwdata[serial_pkg::CONFIG_LEN_LSB +: 4];
    presc_wr = pwdata[serial_pkg::MODE_PRESC_LSB +: 4];
    hit      = 1'b1;
    rd_word  = 32'h00000000;
    case (paddr)
      serial_pkg::MODE_OFS: begin
        rd_word[serial_pkg::MODE_IRQ_SRC_BIT]  = irq_src_reg;
        rd_word[serial_pkg::MODE_PRESC_LSB +: 4] = presc_reg;
      end
      serial_pkg::CONFIG_OFS: begin
        rd_word[serial_pkg::CONFIG_DAP_BIT]      = dap_reg;
        rd_word[serial_pkg::CONFIG_CKP_BIT]      = ckp_reg;
        rd_word[serial_pkg::CONFIG_LSB_BIT]      = lsb_reg;
        rd_word[serial_pkg::CONFIG_LEN_LSB +: 4] = len_m1_reg;
      end
      serial_pkg::BAUD_OFS:   rd_word[6:0]  = baud_reg;
      serial_pkg::DATA_OFS:   rd_word[15:0] = rx_data_reg;
      serial_pkg::STATUS_OFS: begin
        rd_word[serial_pkg::STATUS_OVR_BIT]  = overrun_flag;
        rd_word[serial_pkg::STATUS_FULL_BIT] = full_reg;
        rd_word[serial_pkg::STATUS_BUSY_BIT] =
          (state_reg != serial_pkg::idle_st);
      end
      serial_pkg::CLEAR_OFS:  rd_word = 32'h00000000;
      serial_pkg::START_OFS:  rd_word[serial_pkg::START_RUN_BIT] = enable_reg;
      serial_pkg::OUTCTL_OFS: begin
        rd_word[serial_pkg::OUTCTL_OE_BIT]    = oe_reg;
        rd_word[serial_pkg::OUTCTL_CKIDL_BIT] = ck_idle_reg;
        rd_word[serial_pkg::OUTCTL_DTIDL_BIT] = dt_idle_reg;
      end
      default: hit = 1'b0;
    endcase
    pready_next  = psel && penable && !pready_reg;
    prdata_next  = pready_next ? rd_word : 32'h00000000;
    pslverr_next = pready_next && !hit;
  end

  // Register writes, and the flags that hardware sets and software clears.
  always_comb begin
    irq_src_next = irq_src_reg;
    presc_next   = presc_reg;
    dap_next     = dap_reg;
    ckp_next     = ckp_reg;
    lsb_next     = lsb_reg;
    len_m1_next  = len_m1_reg;
    baud_next    = baud_reg;
    tx_buf_next  = tx_buf_reg;
    full_next    = full_reg;
    rx_data_next = rx_data_reg;
    unread_next  = unread_reg;
    overrun_next = overrun_flag;
    enable_next  = enable_reg;
    oe_next      = oe_reg;
    ck_idle_next = ck_idle_reg;
    dt_idle_next = dt_idle_reg;
    // The shifter taking the buffer empties it before any write lands.
    if (load) begin
      full_next = 1'b0;
    end
    if (rd_ok && paddr == serial_pkg::DATA_OFS) begin
      unread_next = 1'b0;
    end
    if (wr_ok) begin
      case (paddr)
        serial_pkg::MODE_OFS: begin
          irq_src_next = pwdata[serial_pkg::MODE_IRQ_SRC_BIT];
          presc_next   = (presc_wr > serial_pkg::PRESC_MAX) ?
                         serial_pkg::PRESC_MAX : presc_wr;
        end
        serial_pkg::CONFIG_OFS: begin
          dap_next    = pwdata[serial_pkg::CONFIG_DAP_BIT];
          ckp_next    = pwdata[serial_pkg::CONFIG_CKP_BIT];
          lsb_next    = pwdata[serial_pkg::CONFIG_LSB_BIT];
          len_m1_next = (len_wr < serial_pkg::LEN_M1_MIN) ?
                        serial_pkg::LEN_M1_MIN : len_wr;
        end
        serial_pkg::BAUD_OFS: baud_next = pwdata[6:0];
        serial_pkg::DATA_OFS: begin
          tx_buf_next = pwdata[15:0];
          full_next   = 1'b1;
        end
        serial_pkg::CLEAR_OFS: begin
          if (pwdata[serial_pkg::CLEAR_OVR_BIT]) begin
            overrun_next = 1'b0;
          end
        end
        serial_pkg::START_OFS: begin
          if (pwdata[serial_pkg::START_STOP_BIT]) begin
            enable_next = 1'b0;
          end
          if (pwdata[serial_pkg::START_RUN_BIT]) begin
            enable_next = 1'b1;
          end
        end
        serial_pkg::OUTCTL_OFS: begin
          oe_next      = pwdata[serial_pkg::OUTCTL_OE_BIT];
          ck_idle_next = pwdata[serial_pkg::OUTCTL_CKIDL_BIT];
          dt_idle_next = pwdata[serial_pkg::OUTCTL_DTIDL_BIT];
        end
        default: begin
        end
      endcase
    end
    // A finished word wins over a same-cycle read or clear.
    if (finish) begin
      rx_data_next = rx_word;
      unread_next  = 1'b1;
      if (unread_reg && !(rd_ok && paddr == serial_pkg::DATA_OFS)) begin
        overrun_next = 1'b1;
      end
    end
  end

  // Shift sequencer: lead half when dap_reg is set, then a low and a high half for each bit.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    load       = 1'b0;
    shift_out  = 1'b0;
    shift_in   = 1'b0;
    finish     = 1'b0;
    last_bit   = (cnt_reg == len_m1_reg);
    case (state_reg)
      serial_pkg::idle_st: begin
        if (enable_reg && full_reg) begin
          load       = 1'b1;
          cnt_next   = 4'h0;
          state_next = dap_reg ? serial_pkg::lead_st
                               : serial_pkg::low_st;
        end
      end
      serial_pkg::lead_st: begin
        if (tick) begin
          shift_in   = 1'b1;
          state_next = serial_pkg::low_st;
        end
      end
      serial_pkg::low_st: begin
        if (tick) begin
          shift_in   = !dap_reg;
          shift_out  = dap_reg && !last_bit;
          state_next = serial_pkg::high_st;
        end
      end
      serial_pkg::high_st: begin
        if (tick) begin
          if (last_bit) begin
            finish     = 1'b1;
            state_next = serial_pkg::idle_st;
          end else begin
            shift_out  = !dap_reg;
            shift_in   = dap_reg;
            cnt_next   = cnt_reg + 4'h1;
            state_next = serial_pkg::low_st;
          end
        end
      end
      default: state_next = serial_pkg::idle_st;
    endcase
    // Stopping the channel abandons the word in flight.
    if (!enable_reg) begin
      state_next = serial_pkg::idle_st;
      load       = 1'b0;
      finish     = 1'b0;
    end
  end

  // Pin levels and the interrupt pulse, one cycle behind the sequencer.
  always_comb begin
    if (state_reg == serial_pkg::idle_st) begin
      sclk_next = ck_idle_reg;
      sdo_next  = dt_idle_reg;
    end else begin
      sclk_next = (state_reg != serial_pkg::low_st) ^ ckp_reg;
      sdo_next  = out_bit;
    end
    irq_next = irq_src_reg ? load : finish;
  end

  // All state registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_src_reg  <= 1'b0;
      presc_reg    <= serial_pkg::PRESC_RST;
      dap_reg      <= 1'b0;
      ckp_reg      <= 1'b0;
      lsb_reg      <= 1'b0;
      len_m1_reg   <= serial_pkg::LEN_M1_RST;
      baud_reg     <= serial_pkg::BAUD_RST;
      tx_buf_reg   <= 16'h0000;
      full_reg     <= 1'b0;
      rx_data_reg  <= 16'h0000;
      unread_reg   <= 1'b0;
      overrun_flag <= 1'b0;
      enable_reg   <= 1'b0;
      oe_reg       <= serial_pkg::OUTCTL_RST[serial_pkg::OUTCTL_OE_BIT];
      ck_idle_reg  <= serial_pkg::OUTCTL_RST[serial_pkg::OUTCTL_CKIDL_BIT];
      dt_idle_reg  <= serial_pkg::OUTCTL_RST[serial_pkg::OUTCTL_DTIDL_BIT];
      prdata_reg   <= 32'h00000000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      state_reg    <= serial_pkg::idle_st;
      cnt_reg      <= 4'h0;
      sclk_reg     <= 1'b1;
      sdo_reg      <= 1'b1;
      irq_reg      <= 1'b0;
    end else begin
      irq_src_reg  <= irq_src_next;
      presc_reg    <= presc_next;
      dap_reg      <= dap_next;
      ckp_reg      <= ckp_next;
      lsb_reg      <= lsb_next;
      len_m1_reg   <= len_m1_next;
      baud_reg     <= baud_next;
      tx_buf_reg   <= tx_buf_next;
      full_reg     <= full_next;
      rx_data_reg  <= rx_data_next;
      unread_reg   <= unread_next;
      overrun_flag <= overrun_next;
      enable_reg   <= enable_next;
      oe_reg       <= oe_next;
      ck_idle_reg  <= ck_idle_next;
      dt_idle_reg  <= dt_idle_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      sclk_reg     <= sclk_next;
      sdo_reg      <= sdo_next;
      irq_reg      <= irq_next;
    end
  end

  // Outputs come straight from registers.
  assign prdata               = prdata_reg;
  assign pready               = pready_reg;
  assign pslverr              = pslverr_reg;
  assign serial_clock_pin     = sclk_reg;
  assign serial_out_pin       = sdo_reg;
  assign serial_out_oe        = oe_reg;
  assign channel_transfer_irq = irq_reg;

endmodule : three_wire_channel

// ---- verif/three_wire_channel_checker.sv ----
/* Port checker for the three-wire serial channel.
   Assumes the single clk domain and the channel's one-wait-state APB. */
`timescale 1ns/100ps
module three_wire_channel_checker (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial pins and interrupt.
  input wire logic        serial_clock_pin,
  input wire logic        serial_out_pin,
  input wire logic        serial_out_oe,
  input wire logic        serial_in_pin,
  input wire logic        channel_transfer_irq
);
  logic        done;
  logic        bad_addr;
  logic [19:0] half;
  logic [3:0]  presc_reg, presc_next;
  logic [6:0]  div_reg, div_next;
  logic        pin_reg, pin_next;
  logic [19:0] gap_reg, gap_next;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Completed access, address decode and the programmed half period.
  assign done = psel && penable && pready;
  assign bad_addr = (paddr[1:0] != 2'h0) || (paddr > serial_pkg::OUTCTL_OFS);
  assign half = 20'(div_reg + 8'h01) << presc_reg;

  // Mirror of the rate registers and spacing of serial clock edges.
  always_comb begin
    presc_next = presc_reg;
    div_next   = div_reg;
    pin_next   = serial_clock_pin;
    gap_next   = (gap_reg == 20'hFFFFF) ? gap_reg : gap_reg + 20'h1;
    if (serial_clock_pin != pin_reg) begin
      gap_next = 20'h1;
    end
    if (done && pwrite && paddr == serial_pkg::MODE_OFS) begin
      presc_next = (pwdata[7:4] > serial_pkg::PRESC_MAX) ?
                   serial_pkg::PRESC_MAX : pwdata[7:4];
    end
    if (done && pwrite && paddr == serial_pkg::BAUD_OFS) begin
      div_next = pwdata[6:0];
    end
  end

  // Registers of the mirror.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_reg <= serial_pkg::PRESC_RST;
      div_reg   <= serial_pkg::BAUD_RST;
      pin_reg   <= 1'b1;
      gap_reg   <= 20'hFFFFF;
    end else begin
      presc_reg <= presc_next;
      div_reg   <= div_next;
      pin_reg   <= pin_next;
      gap_reg   <= gap_next;
    end
  end

  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_pready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("access did not end after one wait state");
  a_unmapped_err: assert property (pready |-> pslverr == bad_addr)
    else $error("slave error does not match the address decode");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data driven outside a completed access");
  a_status_flags: assert property (done && !pwrite &&
    paddr == serial_pkg::STATUS_OFS |-> prdata[31:3] == 29'h0)
    else $error("status shows flags beyond overrun, full and busy");
  a_oe_follows: assert property (done && pwrite &&
    paddr == serial_pkg::OUTCTL_OFS |=>
    serial_out_oe == $past(pwdata[serial_pkg::OUTCTL_OE_BIT]))
    else $error("output enable does not follow its register write");
  a_irq_single: assert property (channel_transfer_irq |=>
    !channel_transfer_irq)
    else $error("transfer interrupt longer than one cycle");
  a_half_period: assert property (serial_clock_pin != pin_reg |->
    gap_reg >= half)
    else $error("serial clock half period shorter than programmed");
endmodule : three_wire_channel_checker

bind three_wire_channel three_wire_channel_checker u_checker (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_clock_pin(serial_clock_pin),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
  .serial_in_pin(serial_in_pin),
  .channel_transfer_irq(channel_transfer_irq)
);

// ---- verif/serial_slave_model.sv ----
/* Behavioural slave at the far end of the three-wire link.
   Assumes the bench sets phase and polarity and arms a reply per frame. */
`timescale 1ns/100ps
module serial_slave_model (
  // Link setup from the bench.
  input  wire logic        phase,
  input  wire logic        pol,
  input  wire logic        arm,
  input  wire logic [15:0] reply,
  // Serial pins.
  input  wire logic        serial_clock_pin,
  input  wire logic        serial_out_pin,
  output logic             serial_in_pin,
  // Bits heard from the master, latest in bit 0.
  output logic [15:0]      heard
);
  logic [16:0] shift_reg = 17'h0AAAA;

  // Spent bits are refilled inverted so stale data never passes.
  assign serial_in_pin = shift_reg[16];

  // Load on arm, launch on the master's shift edge, listen on the other.
  always @(posedge arm or serial_clock_pin) begin
    if (arm) begin
      shift_reg <= phase ? {reply, ~reply[0]} : {~reply[15], reply};
    end else if ((serial_clock_pin ^ pol) == phase) begin
      shift_reg <= {shift_reg[15:0], ~shift_reg[0]};
    end else begin
      heard <= {heard[14:0], serial_out_pin};
    end
  end
endmodule : serial_slave_model

// ---- verif/test_three_wire_channel.sv ----
/* Self-checking bench of the three-wire serial channel.
   Assumes the slave model answers on the channel's serial clock. */
`timescale 1ns/100ps
module test_three_wire_channel;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } exp_type;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, phase = 1'b0, pol = 1'b0, arm = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h9B2B5545;
  logic        pready, pslverr, sck, sdo, soe, sdi, irq;
  logic [15:0] reply = 16'h0, heard, tx, rx;
  logic [2:0]  cur_cfg;
  exp_type     expq[$];
  int          err_total = 0, n_checks = 0, irq_count = 0, cycles = 0;
  int          cur_n, base;

  three_wire_channel u_dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin(sck), .serial_out_pin(sdo), .serial_out_oe(soe),
    .serial_in_pin(sdi), .channel_transfer_irq(irq));
  serial_slave_model u_slave (.phase(phase), .pol(pol), .arm(arm),
    .reply(reply), .serial_clock_pin(sck), .serial_out_pin(sdo),
    .serial_in_pin(sdi), .heard(heard));

  // A 250 MHz clock.
  initial begin
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // Word as seen on a wire, first bit sent in bit n-1.
  function automatic logic [15:0] order(input logic [15:0] v, input int n,
                                        input logic lsb);
    logic [15:0] r;
    r = 16'h0;
    for (int i = 0; i < n; i++) begin
      r[i] = lsb ? v[n-1-i] : v[i];
    end
    return r;
  endfunction : order

  function automatic logic [15:0] low_mask(input int n);
    return 16'hFFFF >> (16 - n);
  endfunction : low_mask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // One APB transfer; the answer expected is queued for the monitor.
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] m, input logic e);
    expq.push_back({d & m, m, e});
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask : apb

  // Idle levels, frame format and a fresh slave reply.
  task automatic setup(input logic [2:0] cfg, input logic [3:0] lm1);
    cur_cfg = cfg;
    cur_n = int'(lm1) + 1;
    {pol, phase} <= cfg[1:0];
    seed = xorshift(seed);
    reply = seed[31:16];
    apb(1'b1, serial_pkg::OUTCTL_OFS, {29'h0, 1'b1, ~cfg[1], 1'b1},
        0, 0);
    apb(1'b1, serial_pkg::CONFIG_OFS, {24'h0, lm1, 1'b0, cfg}, 0, 0);
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
  endtask : setup

  task automatic heard_ok(input logic [15:0] w);
    check("serial out", {16'h0, order(w, cur_n, cur_cfg[2])},
          {16'h0, heard & low_mask(cur_n)});
  endtask : heard_ok

  // Monitor: pairs each completed access with the oldest expectation.
  always @(posedge clk) begin : monitor
    exp_type x;
    cycles++;
    if (irq === 1'b1) irq_count++;
    if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
      x = expq.pop_front();
      check("read data", x.d, prdata & x.m);
      check("slave error", {31'h0, x.e}, {31'h0, pslverr});
    end
    if (cycles == 40000) begin
      err_total++;
      complete_run();
    end
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, serial_pkg::OUTCTL_OFS, 32'h6, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, serial_pkg::CONFIG_OFS, 32'h70, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, serial_pkg::CLEAR_OFS, 32'h0, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, 8'h20, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 8'h22, 32'h1, 32'h0, 1'b1);
    apb(1'b1, serial_pkg::MODE_OFS, 32'hF0, 0, 0);
    apb(1'b0, serial_pkg::MODE_OFS, 32'hB0, 32'hFF, 1'b0);
    apb(1'b1, serial_pkg::BAUD_OFS, 32'h7F, 0, 0);
    apb(1'b0, serial_pkg::BAUD_OFS, 32'h7F, 32'hFF, 1'b0);
    apb(1'b1, serial_pkg::MODE_OFS, 32'h10, 0, 0);
    apb(1'b1, serial_pkg::BAUD_OFS, 32'h3, 0, 0);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) apb(1'b1, serial_pkg::MODE_OFS, 32'h0, 0, 0);
      seed = xorshift(seed);
      setup(3'(i), (i == 0) ? 4'h6 : (i == 7) ? 4'hF : 4'(6 + seed % 10));
      if (i == 0) apb(1'b1, serial_pkg::START_OFS, 32'h1, 0, 0);
      tx = seed[15:0];
      base = irq_count;
      apb(1'b1, serial_pkg::DATA_OFS, {16'h0, tx}, 0, 0);
      while (irq_count < base + 1) @(posedge clk);
      heard_ok(tx);
      rx = order(reply >> (16 - cur_n), cur_n, cur_cfg[2]);
      apb(1'b0, serial_pkg::DATA_OFS, {16'h0, rx}, {16'h0, low_mask(cur_n)},
        1'b0);
      apb(1'b0, serial_pkg::STATUS_OFS, 32'h0, 32'h7, 1'b0);
    end
    // Continuous run: overwrite of the pending word, source switch.
    setup(3'h7, 4'hF);
    base = irq_count;
    seed = xorshift(seed);
    tx = ~seed[15:0];
    apb(1'b1, serial_pkg::MODE_OFS, 32'h1, 0, 0);
    apb(1'b1, serial_pkg::DATA_OFS, {16'h0, seed[15:0]}, 0, 0);
    apb(1'b1, serial_pkg::DATA_OFS, {16'h0, seed[31:16]}, 0, 0);
    apb(1'b1, serial_pkg::DATA_OFS, {16'h0, tx}, 0, 0);
    apb(1'b0, serial_pkg::STATUS_OFS, 32'h6, 32'h7, 1'b0);
    apb(1'b0, serial_pkg::DATA_OFS, {16'h0, rx}, 32'hFFFF, 1'b0);
    apb(1'b1, serial_pkg::MODE_OFS, 32'h0, 0, 0);
    while (irq_count < base + 3) @(posedge clk);
    heard_ok(tx);
    apb(1'b0, serial_pkg::STATUS_OFS, 32'h1, 32'h7, 1'b0);
    apb(1'b1, serial_pkg::CLEAR_OFS, 32'h1, 0, 0);
    apb(1'b0, serial_pkg::STATUS_OFS, 32'h0, 32'h7, 1'b0);
    apb(1'b1, serial_pkg::START_OFS, 32'h2, 0, 0);
    apb(1'b0, serial_pkg::START_OFS, 32'h0, 32'h1, 1'b0);
    apb(1'b1, serial_pkg::OUTCTL_OFS, 32'h6, 0, 0);
    check("output enable", 32'h0, {31'h0, soe});
    complete_run();
  end
endmodule : test_three_wire_channel
